/* File: core/cies_exec_core.sv */
`default_nettype none
module cies_exec_core
    import cies_pkg::*;
#(
    parameter int PC_W       = 13,
    parameter int PRESCALE_W = 8
)
(
    // Clock, reset and enable.
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              ce,
    // AXI4-Lite write channels.
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read channels.
    input  wire logic [11:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Instruction issue from the sequencer.
    input  wire logic              instr_valid,
    input  wire cies_instr_t       instr,
    output var  logic              instr_ready,
    // Return stack and program counter.
    input  wire logic [PC_W-1:0]   stack_top_entry,
    output var  logic              stack_pop,
    output var  logic              pc_load,
    output var  logic [PC_W-1:0]   pc_value,
    // Power state.
    input  wire logic              wake_req,
    output var  logic              sleep_active,
    output var  cies_flags_t       flags
);

    // ***************************************************************
    // Address decode
    // ***************************************************************
    typedef enum logic [2:0]
    {
        RG_ACC    = 3'h0,
        RG_STATUS = 3'h1,
        RG_WDOG   = 3'h2,
        RG_CTRL   = 3'h3,
        RG_FILE   = 3'h4,
        RG_NONE   = 3'h5
    } cies_region_t;

    // Shared by the read and write paths so both see the same map.
    function automatic cies_region_t decode(input logic [11:0] addr);
        if (addr[1:0] != 2'h0)
            decode = RG_NONE;
        else if (addr == ACC_OFFSET)
            decode = RG_ACC;
        else if (addr == STATUS_OFFSET)
            decode = RG_STATUS;
        else if (addr == WDOG_OFFSET)
            decode = RG_WDOG;
        else if (addr == CTRL_OFFSET)
            decode = RG_CTRL;
        else if (addr[11:9] == FILE_BASE[11:9])
            decode = RG_FILE;
        else
            decode = RG_NONE;
    endfunction

    // ***************************************************************
    // State
    // ***************************************************************
    cies_state_t state_ff;
    cies_state_t nxt_state;
    logic [7:0]  acc_ff;
    logic [7:0]  file_mem [0:127];
    logic        ready_ff;
    logic        pop_ff;
    logic        load_ff;
    logic [PC_W-1:0] pc_ff;
    logic        wdog_clr;
    logic [7:0]  wdog_count;
    logic        wdog_timeout;
    cies_flags_t flags_ff;

    // AXI bookkeeping.
    logic        aw_held_ff, w_held_ff, awready_ff, wready_ff;
    logic        bvalid_ff, arready_ff, rvalid_ff;
    logic [11:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0]  wstrb_ff;
    logic [1:0]  bresp_ff, rresp_ff;

    // ***************************************************************
    // Execute decode
    // ***************************************************************
    logic         issue, lit_op, reg_op, to_acc, to_file, bus_wake, wr_fire;
    logic         alu_c, alu_dc, alu_z, upd_arith, upd_zero;
    logic [7:0]   operand, alu_result;
    cies_region_t wr_region;

    assign issue   = ce && instr_valid && ready_ff && (state_ff == ST_IDLE);
    assign lit_op  = (instr.op == CIES_OP_SUB_LIT) || (instr.op == CIES_OP_XOR_LIT);
    assign reg_op  = (instr.op == CIES_OP_SUB_REG) || (instr.op == CIES_OP_XOR_REG)
                     || (instr.op == CIES_OP_SWAP);
    assign operand = lit_op ? instr.literal : file_mem[instr.addr];

    // Literal forms always land in the accumulator; register forms follow d.
    assign to_acc  = issue && (lit_op || (reg_op && !instr.dest));
    assign to_file = issue && reg_op && instr.dest;

    cies_alu u_alu
    (
        .op          (instr.op),
        .acc         (acc_ff),
        .operand     (operand),
        .result      (alu_result),
        .carry       (alu_c),
        .digit_carry (alu_dc),
        .zero        (alu_z),
        .upd_arith   (upd_arith),
        .upd_zero    (upd_zero)
    );

    assign wdog_clr = issue && (instr.op == CIES_OP_HALT);

    cies_wdog #(.PRESCALE_W(PRESCALE_W)) u_wdog
    (
        .clk        (clk),
        .srst       (srst),
        .ce         (ce),
        .clear      (wdog_clr),
        .count_ff   (wdog_count),
        .timeout_ff (wdog_timeout)
    );

    // ***************************************************************
    // Sequencing
    // ***************************************************************
    assign wr_fire   = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_region = decode(awaddr_ff);
    assign bus_wake  = wr_fire && (wr_region == RG_CTRL) && wstrb_ff[0]
                       && wdata_ff[CTRL_WAKE_BIT];

    // Return holds the core one extra cycle; halt parks it until a wake.
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
                if (issue && (instr.op == CIES_OP_RETURN))
                    nxt_state = ST_RET;
                else if (issue && (instr.op == CIES_OP_HALT))
                    nxt_state = ST_ASLEEP;
            ST_RET:
                nxt_state = ST_IDLE;
            ST_ASLEEP:
                if (wake_req || bus_wake || wdog_timeout)
                    nxt_state = ST_IDLE;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    // State register and the issue handshake, which drops in return and sleep.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_ff <= ST_IDLE;
            ready_ff <= 1'b0;
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
            ready_ff <= (nxt_state == ST_IDLE);
        end
    end

    // Pop in the cycle after issue, load the program counter in the second cycle.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pop_ff  <= 1'b0;
            load_ff <= 1'b0;
            pc_ff   <= '0;
        end
        else if (ce)
        begin
            pop_ff  <= issue && (instr.op == CIES_OP_RETURN);
            load_ff <= (state_ff == ST_RET);
            if (issue && (instr.op == CIES_OP_RETURN))
                pc_ff <= stack_top_entry;
        end
    end

    // ***************************************************************
    // Accumulator, file registers and flags
    // ***************************************************************
    // An instruction result beats a bus write in the same cycle.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            acc_ff <= ACC_RESET;
        end
        else if (ce)
        begin
            if (to_acc)
                acc_ff <= alu_result;
            else if (wr_fire && (wr_region == RG_ACC) && wstrb_ff[0])
                acc_ff <= wdata_ff[7:0];
        end
    end

    // The file space is plain storage, so it carries no reset.
    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            if (to_file)
                file_mem[instr.addr] <= alu_result;
            else if (wr_fire && (wr_region == RG_FILE) && wstrb_ff[0])
                file_mem[awaddr_ff[8:2]] <= wdata_ff[7:0];
        end
    end

    // Return and swap leave every flag alone by never raising a mask.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            flags_ff                   <= '0;
            flags_ff.power_down_flag_n <= PD_N_RESET;
            flags_ff.timeout_flag_n    <= TO_N_RESET;
        end
        else if (ce)
        begin
            if (issue && upd_zero)
                flags_ff.zero_flag <= alu_z;
            if (issue && upd_arith)
            begin
                flags_ff.carry_flag       <= alu_c;
                flags_ff.digit_carry_flag <= alu_dc;
            end
            if (wdog_clr)
            begin
                flags_ff.power_down_flag_n <= 1'b0;
                flags_ff.timeout_flag_n    <= 1'b1;
            end
            if (wdog_timeout)
                flags_ff.timeout_flag_n <= 1'b0;
        end
    end

    // ***************************************************************
    // AXI4-Lite slave
    // ***************************************************************
    // Address and data are taken in either order; one write is open at a time.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
            awaddr_ff  <= '0;
            wdata_ff   <= '0;
            wstrb_ff   <= '0;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && awready_ff)
            begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_held_ff <= 1'b0;
            if (s_axi_wvalid && wready_ff)
            begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_held_ff <= 1'b0;
            awready_ff <= !aw_held_ff && !(s_axi_awvalid && awready_ff) && !bvalid_ff
                          && !wr_fire;
            wready_ff  <= !w_held_ff && !(s_axi_wvalid && wready_ff) && !bvalid_ff
                          && !wr_fire;
            if (wr_fire)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= (wr_region == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
            else if (s_axi_bready)
                bvalid_ff <= 1'b0;
        end
    end

    // Reads answer one cycle after the address is taken.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= '0;
            rresp_ff   <= RESP_OKAY;
        end
        else if (ce)
        begin
            arready_ff <= !(s_axi_arvalid && arready_ff) && !(rvalid_ff && !s_axi_rready);
            if (s_axi_arvalid && arready_ff)
            begin
                rvalid_ff <= 1'b1;
                rresp_ff  <= RESP_OKAY;
                rdata_ff  <= '0;
                case (decode(s_axi_araddr))
                    RG_ACC:    rdata_ff[7:0] <= acc_ff;
                    RG_STATUS: rdata_ff[5:0] <= {(state_ff == ST_ASLEEP), flags_ff};
                    RG_WDOG:   rdata_ff[7:0] <= wdog_count;
                    RG_FILE:   rdata_ff[7:0] <= file_mem[s_axi_araddr[8:2]];
                    RG_CTRL:   rdata_ff      <= '0;
                    default:   rresp_ff      <= RESP_SLVERR;
                endcase
            end
            else if (s_axi_rready)
                rvalid_ff <= 1'b0;
        end
    end

    // ***************************************************************
    // Outputs, all straight from flip-flops
    // ***************************************************************
    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign instr_ready   = ready_ff;
    assign stack_pop     = pop_ff;
    assign pc_load       = load_ff;
    assign pc_value      = pc_ff;
    assign sleep_active  = state_ff[2];
    assign flags         = flags_ff;

endmodule
`default_nettype wire

/* File: shared/cies_pkg.sv */
// Functional notes
// - Return pops the stack into the program counter in two cycles and keeps all flags.
// - Halt clears the watchdog count to 00h and clears its prescaler.
// - Halt clears active-low power-down, sets active-low timeout and keeps other flags.
// - After halt the core executes nothing until a wake-up.
// - Literal subtract loads literal minus accumulator, updating carries and zero.
// - Register subtract takes register 0 to 127 minus accumulator, updating carries and zero.
// - Destination bit 0 sends a register result to the accumulator and 1 back to the register.
// - Literal XOR puts accumulator XOR literal in the accumulator and updates only zero.
// - Register XOR combines accumulator and register, routes by destination, updates only zero.
// - Nibble swap exchanges the register's two nibbles and touches no flag.
`default_nettype none
package cies_pkg;

    // ***************************************************************
    // Bus map and field positions
    // ***************************************************************
    localparam logic [11:0] ACC_OFFSET    = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] WDOG_OFFSET   = 12'h008;
    localparam logic [11:0] CTRL_OFFSET   = 12'h00c;
    localparam logic [11:0] FILE_BASE     = 12'h200;
    localparam int          CTRL_WAKE_BIT = 0;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ***************************************************************
    // Reset values and timing
    // ***************************************************************
    localparam logic [7:0]  ACC_RESET     = 8'h00;
    localparam logic        PD_N_RESET    = 1'h1;
    localparam logic        TO_N_RESET    = 1'h1;
    localparam logic [7:0]  WDOG_CLEARED  = 8'h00;
    localparam int          RETURN_CYCLES = 2;

    // ***************************************************************
    // Types
    // ***************************************************************
    typedef enum logic [2:0]
    {
        CIES_OP_RETURN   = 3'h0,
        CIES_OP_HALT     = 3'h1,
        CIES_OP_SUB_LIT  = 3'h2,
        CIES_OP_SUB_REG  = 3'h3,
        CIES_OP_XOR_LIT  = 3'h4,
        CIES_OP_XOR_REG  = 3'h5,
        CIES_OP_SWAP     = 3'h6,
        CIES_OP_NONE     = 3'h7
    } cies_op_t;

    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'b001,
        ST_RET    = 3'b010,
        ST_ASLEEP = 3'b100
    } cies_state_t;

    typedef struct packed
    {
        cies_op_t   op;
        logic [7:0] literal;
        logic [6:0] addr;
        logic       dest;
    } cies_instr_t;

    typedef struct packed
    {
        logic timeout_flag_n;
        logic power_down_flag_n;
        logic zero_flag;
        logic digit_carry_flag;
        logic carry_flag;
    } cies_flags_t;

endpackage
`default_nettype wire

/* File: core/cies_alu.sv */
`default_nettype none
module cies_alu
    import cies_pkg::*;
(
    // Operation and operands.
    input  wire cies_op_t   op,
    input  wire logic [7:0] acc,
    input  wire logic [7:0] operand,
    // Result and flags.
    output var  logic [7:0] result,
    output var  logic       carry,
    output var  logic       digit_carry,
    output var  logic       zero,
    output var  logic       upd_arith,
    output var  logic       upd_zero
);

    logic [8:0] diff;
    logic [4:0] low_diff;

    // Two's complement subtraction: operand plus inverted accumulator plus one.
    assign diff     = {1'b0, operand} + {1'b0, ~acc} + 9'h001;
    assign low_diff = {1'b0, operand[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

    // Result select and flag update masks.
    always_comb
    begin
        result    = operand;
        upd_arith = 1'b0;
        upd_zero  = 1'b0;
        case (op)
            CIES_OP_SUB_LIT, CIES_OP_SUB_REG:
            begin
                result    = diff[7:0];
                upd_arith = 1'b1;
                upd_zero  = 1'b1;
            end
            CIES_OP_XOR_LIT, CIES_OP_XOR_REG:
            begin
                result   = acc ^ operand;
                upd_zero = 1'b1;
            end
            CIES_OP_SWAP:
            begin
                result = {operand[3:0], operand[7:4]};
            end
        endcase
    end

    // Carry set means no borrow; zero tracks the final result.
    assign carry       = diff[8];
    assign digit_carry = low_diff[4];
    assign zero        = (result == 8'h00);

endmodule
`default_nettype wire

/* File: core/cies_wdog.sv */
`default_nettype none
module cies_wdog
    import cies_pkg::*;
#(
    parameter int PRESCALE_W = 8
)
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       ce,
    // Control.
    input  wire logic       clear,
    // Status.
    output var  logic [7:0] count_ff,
    output var  logic       timeout_ff
);

    logic [PRESCALE_W-1:0] prescale_ff;

    // Prescaler; a clear restarts the whole chain so a halt gives a full period.
    always_ff @(posedge clk)
    begin
        if (srst || (ce && clear))
        begin
            prescale_ff <= '0;
        end
        else if (ce)
        begin
            prescale_ff <= prescale_ff + 1'b1;
        end
    end

    // Watchdog counter steps on prescaler wrap and pulses on its own wrap.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            count_ff   <= WDOG_CLEARED;
            timeout_ff <= 1'b0;
        end
        else if (ce)
        begin
            timeout_ff <= 1'b0;
            if (clear)
            begin
                count_ff <= WDOG_CLEARED;
            end
            else if (&prescale_ff)
            begin
                count_ff   <= count_ff + 8'h01;
                timeout_ff <= &count_ff;
            end
        end
    end

endmodule
`default_nettype wire

/* File: verification/cies_checker.sv */
`default_nettype none
module cies_checker
    import cies_pkg::*;
#(
    parameter int PC_W = 13
)
(
    // Clock and reset.
    input wire logic            clk,
    input wire logic            srst,
    input wire logic            ce,
    // Instruction side.
    input wire logic            instr_valid,
    input wire cies_instr_t     instr,
    input wire logic            instr_ready,
    input wire logic [PC_W-1:0] stack_top_entry,
    input wire logic            stack_pop,
    input wire logic            pc_load,
    input wire logic [PC_W-1:0] pc_value,
    input wire logic            sleep_active,
    input wire cies_flags_t     flags
);
    // ****
    // Instruction checks
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // A frozen core takes nothing, so ce is part of every take.
    logic go;
    assign go = instr_valid && instr_ready && ce;
    a_ret_pop: assert property (go && instr.op == CIES_OP_RETURN |=>
        stack_pop && !instr_ready) else $error("return did not pop");
    a_ret_load: assert property (go && instr.op == CIES_OP_RETURN |=>
        ##1 pc_load && pc_value == $past(stack_top_entry, 2)) else $error("return pc wrong");
    a_ret_pulse: assert property (go && instr.op == CIES_OP_RETURN |=>
        !pc_load ##1 pc_load ##1 !pc_load && !stack_pop) else $error("return timing wrong");
    a_ret_flags: assert property (go && instr.op == CIES_OP_RETURN |=>
        ##1 flags[2:0] == $past(flags[2:0], 2)) else $error("return changed flags");
    a_halt_sleep: assert property (go && instr.op == CIES_OP_HALT |=>
        sleep_active && !instr_ready) else $error("halt did not sleep");
    a_halt_flags: assert property (go && instr.op == CIES_OP_HALT |=>
        !flags[3] && flags[4] && flags[2:0] == $past(flags[2:0])) else $error("halt flags wrong");
    a_swap_flags: assert property (go && instr.op == CIES_OP_SWAP |=>
        $stable(flags[2:0])) else $error("swap changed flags");
    a_xor_carry: assert property (go && instr.op[2:1] == 2'b10
        |=> flags[1:0] == $past(flags[1:0])) else $error("xor changed carries");
endmodule
bind cies_exec_core cies_checker #(.PC_W(PC_W)) i_chk (.*);
`default_nettype wire

/* File: verification/cies_stack_model.sv */
`default_nettype none
module cies_stack_model
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        srst,
    // Pop request and top entry.
    input  wire logic        stack_pop,
    output var  logic [12:0] stack_top_entry
);
    // Each pop shows a new entry, so a stale top cannot pass for a fresh one.
    always_ff @(posedge clk)
    begin
        if (srst)
            stack_top_entry <= 13'h1a5c;
        else if (stack_pop)
            stack_top_entry <= stack_top_entry ^ 13'h0f0f;
    end
endmodule
`default_nettype wire

/* File: verification/cies_exec_core_tb.sv */
`default_nettype none
module cies_exec_core_tb
    import cies_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Bench signals
    // ****
    logic        clk, srst, ce, wake_req, stack_pop, pc_load, sleep_active;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        instr_valid, instr_ready;
    cies_instr_t instr;
    logic [12:0] stack_top_entry, pc_value;
    cies_flags_t flags;
    int          num_errors, compares;
    // Free-running 50 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    cies_exec_core i_dut
    (
        .clk, .srst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .instr_valid, .instr, .instr_ready,
        .stack_top_entry, .stack_pop, .pc_load, .pc_value, .wake_req, .sleep_active, .flags
    );
    cies_stack_model i_stack (.clk, .srst, .stack_pop, .stack_top_entry);
    // ****
    // Shared tasks
    // ****
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Bready is up from the start so the answer is taken at the edge it is seen.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic issue(input cies_op_t op, input logic [7:0] k, input logic [6:0] a,
                         input logic d);
        @(posedge clk);
        instr <= '{op, k, a, d};
        instr_valid <= 1'b1;
        do
            @(posedge clk);
        while (!instr_ready);
        instr_valid <= 1'b0;
    endtask
    // Expected flags start from the live status, since most ops keep some flags.
    task automatic run_op(input cies_op_t op, input logic [7:0] k, input logic [6:0] a,
                          input logic d, input logic [7:0] w, input logic [7:0] f);
        logic [31:0] st, v;
        logic [1:0]  rs;
        logic [7:0]  src, r;
        logic        lit, tf;
        lit = (op == CIES_OP_SUB_LIT) || (op == CIES_OP_XOR_LIT);
        tf = d && !lit;
        src = lit ? k : f;
        wr(ACC_OFFSET, w);
        wr(FILE_BASE + {3'h0, a, 2'h0}, f);
        rd(STATUS_OFFSET, st, rs);
        r = (op == CIES_OP_SWAP) ? {f[3:0], f[7:4]} : src ^ w;
        if (op == CIES_OP_SUB_LIT || op == CIES_OP_SUB_REG)
        begin
            r = src - w;
            st[0] = src >= w;
            st[1] = src[3:0] >= w[3:0];
        end
        if (op != CIES_OP_SWAP)
            st[2] = (r == 8'h00);
        issue(op, k, a, d);
        rd(ACC_OFFSET, v, rs);
        check(v, {24'h0, tf ? w : r});
        rd(FILE_BASE + {3'h0, a, 2'h0}, v, rs);
        check(v, {24'h0, tf ? r : f});
        rd(STATUS_OFFSET, v, rs);
        check(v, st);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset;
        logic [31:0] v;
        logic [1:0]  r;
        rd(STATUS_OFFSET, v, r);
        check(v, 32'h18);
        rd(12'h100, v, r);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(12'h100, 8'h00);
        check({30'h0, s_axi_bresp}, {30'h0, RESP_SLVERR});
        $display("reset test done");
    endtask
    task automatic t_arith;
        run_op(CIES_OP_SUB_LIT, 8'h01, 7'h00, 1'b0, 8'h01, 8'h00);
        run_op(CIES_OP_SUB_LIT, 8'h01, 7'h00, 1'b1, 8'h02, 8'h00);
        run_op(CIES_OP_SUB_LIT, 8'h10, 7'h00, 1'b0, 8'h01, 8'h00);
        run_op(CIES_OP_SUB_REG, 8'h00, 7'h7f, 1'b1, 8'h11, 8'h30);
        run_op(CIES_OP_SUB_REG, 8'h00, 7'h7f, 1'b0, 8'h40, 8'h30);
        run_op(CIES_OP_XOR_LIT, 8'h5a, 7'h00, 1'b0, 8'h5a, 8'h00);
        run_op(CIES_OP_XOR_LIT, 8'h0f, 7'h00, 1'b1, 8'hf0, 8'h00);
        run_op(CIES_OP_XOR_REG, 8'h00, 7'h01, 1'b1, 8'hc3, 8'h3c);
        run_op(CIES_OP_XOR_REG, 8'h00, 7'h01, 1'b0, 8'h77, 8'h77);
        run_op(CIES_OP_SWAP, 8'h00, 7'h02, 1'b0, 8'h3c, 8'ha5);
        run_op(CIES_OP_SWAP, 8'h00, 7'h02, 1'b1, 8'h3c, 8'h1e);
        $display("arithmetic test done");
    endtask
    task automatic t_return;
        logic [12:0] e;
        for (int i = 0; i < 2; i++)
        begin
            e = stack_top_entry;
            issue(CIES_OP_RETURN, 8'h00, 7'h00, 1'b0);
            repeat (2) @(posedge clk);
            check({31'h0, pc_load}, 32'h1);
            check({19'h0, pc_value}, {19'h0, e});
        end
        $display("return test done");
    endtask
    // The wait lets the watchdog count up so that its clearing is visible.
    task automatic t_halt;
        logic [31:0] st, v;
        logic [1:0]  r;
        repeat (600) @(posedge clk);
        rd(WDOG_OFFSET, v, r);
        check({31'h0, v != 32'h0}, 32'h1);
        rd(STATUS_OFFSET, st, r);
        issue(CIES_OP_HALT, 8'h00, 7'h00, 1'b0);
        rd(WDOG_OFFSET, v, r);
        check(v, {24'h0, WDOG_CLEARED});
        rd(STATUS_OFFSET, v, r);
        check(v, {26'h0, 3'b110, st[2:0]});
        check({31'h0, instr_ready}, 32'h0);
        wake_req <= 1'b1;
        @(posedge clk);
        wake_req <= 1'b0;
        repeat (2) @(posedge clk);
        check({31'h0, sleep_active}, 32'h0);
        $display("halt test done");
    endtask
    task automatic conclude;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Main sequence; ce stays high because a frozen core would stall every wait.
    initial
    begin
        {srst, ce, s_axi_wstrb} = 6'h3f;
        {wake_req, instr_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        instr = '0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_reset;
        t_arith;
        t_return;
        t_halt;
        conclude;
    end
    // Hang guard well beyond the expected run length.
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        conclude;
    end
endmodule
`default_nettype wire
